/* File: core/bsf_conv_enc.v */
`timescale 1ns/1ps
`include "bsf_map.vh"

// Rate one-half, constraint-length seven convolutional encoder.
module bsf_conv_enc (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_step,
	input wire i_bit,
	output wire [1:0] o_code,
	output wire o_at_zero
);

	reg [`BSF_ENC_MEM_W-1:0] state_ff;
	wire [`BSF_ENC_MEM_W:0] taps;

	// Newest bit in the top position, then the six remembered bits.
	assign taps = {i_bit, state_ff};
	assign o_code = {^(taps & `BSF_POLY_A), ^(taps & `BSF_POLY_B)};
	assign o_at_zero = (state_ff == `BSF_ENC_ZERO);

	// The state moves only on a step; without a step it holds.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			state_ff <= `BSF_ENC_ZERO;
		else if (i_step)
			state_ff <= taps[`BSF_ENC_MEM_W:1];
	end

endmodule // bsf_conv_enc

/* File: core/bsf_fifo.v */
`timescale 1ns/1ps
`include "bsf_map.vh"

// Word buffer in front of the formatter; ready comes from a register.
module bsf_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_in_valid,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_in_ready,
	output wire o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input wire i_out_ready
);

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	reg ready_ff;
	reg [AW:0] nxt_count;
	wire push;
	wire pop;

	assign push = i_in_valid && ready_ff;
	assign pop = i_out_ready && (count_ff != {(AW+1){1'b0}});
	assign o_in_ready = ready_ff;
	assign o_out_valid = (count_ff != {(AW+1){1'b0}});
	assign o_out_data = mem_ff[rd_ptr_ff];

	// Next fill level, counting simultaneous push and pop as no change.
	always @*
	begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
	end

	// Pointers, level and the registered ready flag.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			ready_ff <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			count_ff <= nxt_count;
			ready_ff <= (nxt_count != DEPTH[AW:0]);
		end
	end

	// Storage is written without reset; only read once valid.
	always @(posedge i_sys_clk)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= i_in_data;
	end

endmodule // bsf_fifo

/* File: core/bsf_formatter.v */
`timescale 1ns/1ps
`include "bsf_map.vh"

// Summary of operation
// - Payload is fetched only after the header-done pulse arrives.
// - Each 11-bit word splits into groups of three, three, three, two bits.
// - First two bits of a 3-bit group pass through; third feeds the encoder.
// - The two encoder outputs form the symbol's low two bits.
// - Fourth symbol of a word carries the 2-bit group over forced zeros.
// - On every fourth symbol the encoder holds state and is not used.
// - Last 16 bits make eight symbols; six zeros flush the encoder.
// - Encoder starts each burst at zero since the last one flushed it.
// - Tail symbols one and two take the first group, then group two's first bit.
// - Tail symbol three takes middle and last of group two, coded zero.
// - Tail symbol four takes group three's first two bits over zeros.
// - Tail symbol five: group three's last bit and 2-bit group's first.
// - Tail symbol six: 2-bit group's last bit, final word's first bit.
// - Tail symbol seven: next two bits, last zero clocked into encoder.
// - Tail symbol eight: final two data bits over forced zeros.
module bsf_formatter (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_header_done,
	input wire i_word_valid,
	input wire [`BSF_WORD_W-1:0] i_word,
	input wire i_word_tail,
	output wire o_word_ready,
	output reg [`BSF_SYM_W-1:0] o_sym_ff,
	output reg o_sym_valid_ff,
	input wire i_sym_ready,
	output reg o_busy_ff,
	output reg o_burst_done_ff
);

	reg [`BSF_ST_W-1:0] state_ff;
	reg [`BSF_ST_W-1:0] nxt_state;
	reg [`BSF_SHIFT_W-1:0] shift_ff;
	reg [`BSF_SHIFT_W-1:0] nxt_shift;
	reg [`BSF_CNT_W-1:0] cnt_ff;
	reg [`BSF_CNT_W-1:0] nxt_cnt;
	reg [`BSF_SYM_W-1:0] nxt_sym;
	reg nxt_sym_valid;
	reg nxt_done;
	reg enc_step;
	reg enc_bit;
	reg fifo_pop;
	wire fifo_valid;
	wire [`BSF_WORD_W:0] fifo_data;
	wire [`BSF_WORD_W:0] in_data;
	wire [1:0] enc_code;
	wire out_free;
	wire pause_slot;
	wire fifo_tail;
	wire [`BSF_WORD_W-1:0] fifo_word;

	// Pause slot test, shared by normal words and the tail.
	function is_pause;
		input [`BSF_CNT_W-1:0] cnt;
		begin
			is_pause = (cnt[1:0] == `BSF_PAUSE_SLOT);
		end
	endfunction

	// Symbol built from two upper bits and two low bits.
	function [`BSF_SYM_W-1:0] make_sym;
		input [1:0] upper;
		input [1:0] lower;
		begin
			make_sym = {upper, lower};
		end
	endfunction

	// Leading pair of the symbol shift register: the next upper bits.
	function [1:0] top_pair;
		input [`BSF_SHIFT_W-1:0] sh;
		begin
			top_pair = sh[`BSF_TOP_HI:`BSF_TOP_LO];
		end
	endfunction

	// Drops one 3-bit group: two pass-through bits and the coded bit.
	function [`BSF_SHIFT_W-1:0] drop_group;
		input [`BSF_SHIFT_W-1:0] sh;
		begin
			drop_group = {sh[`BSF_ENC_BIT-1:0], 3'h0};
		end
	endfunction

	// Drops one pair of tail bits; zeros fill from the bottom.
	function [`BSF_SHIFT_W-1:0] drop_pair;
		input [`BSF_SHIFT_W-1:0] sh;
		begin
			drop_pair = {sh[`BSF_ENC_BIT:0], `BSF_LOW_ZERO};
		end
	endfunction

	// Symbol counter step; every fetch restarts the count at zero.
	function [`BSF_CNT_W-1:0] count_up;
		input [`BSF_CNT_W-1:0] cnt;
		begin
			count_up = cnt + `BSF_CNT_ONE;
		end
	endfunction

	// True on the last of the eight tail symbols.
	function is_tail_end;
		input [`BSF_CNT_W-1:0] cnt;
		begin
			is_tail_end = (cnt == `BSF_TERM_LAST);
		end
	endfunction

	// A normal word, left aligned above zero padding.
	function [`BSF_SHIFT_W-1:0] load_word;
		input [`BSF_WORD_W-1:0] word;
		begin
			load_word = {word, `BSF_PAD_ZERO};
		end
	endfunction

	// The tail flag travels beside each word through the buffer.
	assign in_data = {i_word_tail, i_word};

	// Word buffer; its registered ready stalls the word source.
	bsf_fifo #(
		.WIDTH(`BSF_WORD_W + 1),
		.DEPTH(`BSF_FIFO_DEPTH),
		.AW(`BSF_FIFO_AW)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_in_valid(i_word_valid),
		.i_in_data(in_data),
		.o_in_ready(o_word_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// Encoder; it is never reset between bursts, only at power up.
	bsf_conv_enc u_enc (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_step(enc_step),
		.i_bit(enc_bit),
		.o_code(enc_code),
		.o_at_zero()
	);

	// A new symbol may be loaded when the output holds none or is taken.
	assign out_free = !o_sym_valid_ff || i_sym_ready;
	assign pause_slot = is_pause(cnt_ff);

	// Tail flag and payload bits of the word at the buffer head.
	assign fifo_tail = fifo_data[`BSF_WORD_W];
	assign fifo_word = fifo_data[`BSF_WORD_W-1:0];

	// Sequencer: fetch a word, split it into symbols, run the tail.
	always @*
	begin
		nxt_state = state_ff;
		nxt_shift = shift_ff;
		nxt_cnt = cnt_ff;
		nxt_sym = o_sym_ff;
		nxt_sym_valid = o_sym_valid_ff && !i_sym_ready;
		nxt_done = 1'b0;
		enc_step = 1'b0;
		enc_bit = 1'b0;
		fifo_pop = 1'b0;
		case (state_ff)
			`BSF_ST_IDLE:
			begin
				// Header symbols are out; payload may now be read.
				if (i_header_done)
					nxt_state = `BSF_ST_FETCH;
			end
			`BSF_ST_FETCH:
			begin
				// Take one word, left aligned in the shift register.
				if (fifo_valid)
				begin
					fifo_pop = 1'b1;
					nxt_shift = load_word(fifo_word);
					nxt_cnt = `BSF_CNT_ZERO;
					if (fifo_tail)
						nxt_state = `BSF_ST_FETCH_B;
					else
						nxt_state = `BSF_ST_EMIT_N;
				end
			end
			`BSF_ST_FETCH_B:
			begin
				// Final word: its first five bits complete the 16.
				if (fifo_valid)
				begin
					fifo_pop = 1'b1;
					nxt_shift = {shift_ff[`BSF_SHIFT_W-1:`BSF_TAIL_W],
						fifo_word[`BSF_WORD_W-1:
						`BSF_WORD_W-`BSF_TAIL_W]};
					nxt_cnt = `BSF_CNT_ZERO;
					nxt_state = `BSF_ST_EMIT_T;
				end
			end
			`BSF_ST_EMIT_N:
			begin
				if (out_free)
				begin
					nxt_sym_valid = 1'b1;
					nxt_cnt = count_up(cnt_ff);
					if (pause_slot)
					begin
						// Two-bit group over zeros; encoder paused.
						nxt_sym = make_sym(
							top_pair(shift_ff),
							`BSF_LOW_ZERO);
						nxt_state = `BSF_ST_FETCH;
					end
					else
					begin
						// Two pass-through bits over the coded pair.
						enc_step = 1'b1;
						enc_bit = shift_ff[`BSF_ENC_BIT];
						nxt_sym = make_sym(
							top_pair(shift_ff),
							enc_code);
						nxt_shift = drop_group(shift_ff);
					end
				end
			end
			`BSF_ST_EMIT_T:
			begin
				// Tail: every bit passes through, two per symbol.
				if (out_free)
				begin
					nxt_sym_valid = 1'b1;
					nxt_cnt = count_up(cnt_ff);
					nxt_shift = drop_pair(shift_ff);
					if (pause_slot)
					begin
						nxt_sym = make_sym(
							top_pair(shift_ff),
							`BSF_LOW_ZERO);
					end
					else
					begin
						// Zeros enter the encoder to flush it.
						enc_step = 1'b1;
						enc_bit = 1'b0;
						nxt_sym = make_sym(
							top_pair(shift_ff),
							enc_code);
					end
					if (is_tail_end(cnt_ff))
					begin
						nxt_state = `BSF_ST_IDLE;
						nxt_done = 1'b1;
					end
				end
			end
			default:
			begin
				nxt_state = `BSF_ST_IDLE;
			end
		endcase
	end

	// Sequencer state, bit shift register and symbol counter.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_ff <= `BSF_ST_IDLE;
			shift_ff <= {`BSF_SHIFT_W{1'b0}};
			cnt_ff <= `BSF_CNT_ZERO;
		end
		else
		begin
			state_ff <= nxt_state;
			shift_ff <= nxt_shift;
			cnt_ff <= nxt_cnt;
		end
	end

	// Symbol output stage; it holds until the modulator side takes it.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_sym_ff <= {`BSF_SYM_W{1'b0}};
			o_sym_valid_ff <= 1'b0;
		end
		else
		begin
			o_sym_ff <= nxt_sym;
			o_sym_valid_ff <= nxt_sym_valid;
		end
	end

	// Status flags; busy falls as the last tail symbol is loaded.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_busy_ff <= 1'b0;
			o_burst_done_ff <= 1'b0;
		end
		else
		begin
			o_busy_ff <= (nxt_state != `BSF_ST_IDLE);
			o_burst_done_ff <= nxt_done;
		end
	end

endmodule // bsf_formatter

/* File: core/bsf_map.vh */
`ifndef BSF_MAP_VH
`define BSF_MAP_VH

// Widths of the payload word and the modulator symbol.
`define BSF_WORD_W 11
`define BSF_SYM_W 4
`define BSF_SHIFT_W 16
`define BSF_FIFO_DEPTH 8
`define BSF_FIFO_AW 3

// Formatter states.
`define BSF_ST_W 3
`define BSF_ST_IDLE 3'h0
`define BSF_ST_FETCH 3'h1
`define BSF_ST_FETCH_B 3'h2
`define BSF_ST_EMIT_N 3'h3
`define BSF_ST_EMIT_T 3'h4

// Symbol counters and their end values.
`define BSF_CNT_W 3
`define BSF_CNT_ZERO 3'h0
`define BSF_CNT_ONE 3'h1
`define BSF_PAUSE_SLOT 2'h3
`define BSF_NORM_LAST 3'h3
`define BSF_TERM_LAST 3'h7

// Bit positions inside the 16-bit symbol shift register.
`define BSF_TOP_HI 15
`define BSF_TOP_LO 14
`define BSF_ENC_BIT 13
`define BSF_PAD_W 5
`define BSF_PAD_ZERO 5'h00
`define BSF_TAIL_W 5

// Forced low bits of every fourth symbol.
`define BSF_LOW_ZERO 2'h0

// Encoder: constraint length seven, six memory bits, 171 and 133 octal.
`define BSF_ENC_MEM_W 6
`define BSF_ENC_ZERO 6'h00
`define BSF_POLY_A 7'h79
`define BSF_POLY_B 7'h5B

`endif

/* File: testbench/bsf_formatter_props.sv */
`timescale 1ns/1ps
module bsf_formatter_props (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_header_done,
	input wire o_word_ready,
	input wire [3:0] o_sym_ff,
	input wire o_sym_valid_ff,
	input wire i_sym_ready,
	input wire o_busy_ff,
	input wire o_burst_done_ff
);
	reg [1:0] slot_ff;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// Counts accepted symbols, so the slot within four is known.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			slot_ff <= 2'h0;
		else if (o_sym_valid_ff && i_sym_ready)
			slot_ff <= slot_ff + 2'h1;
	end
	sym_hold_a: assert property (o_sym_valid_ff && !i_sym_ready |=>
		o_sym_valid_ff && $stable(o_sym_ff)) else $error("symbol moved");
	fourth_zero_a: assert property (o_sym_valid_ff && slot_ff == 2'h3
		|-> o_sym_ff[1:0] == 2'h0) else $error("slot four not zero");
	early_sym_a: assert property ($rose(o_sym_valid_ff) |-> o_busy_ff)
		else $error("symbol while idle");
	busy_cause_a: assert property ($rose(o_busy_ff) |->
		$past(i_header_done) || $past(i_header_done, 2) ||
		$past(i_header_done, 3)) else $error("busy without header");
	header_go_a: assert property (!o_busy_ff && !o_sym_valid_ff &&
		i_header_done |-> ##[1:3] o_busy_ff) else $error("header ignored");
	done_pulse_a: assert property (o_burst_done_ff |=> !o_burst_done_ff)
		else $error("done too long");
	done_last_a: assert property (o_burst_done_ff |-> o_sym_valid_ff &&
		o_sym_ff[1:0] == 2'h0 && slot_ff == 2'h3) else $error("bad last");
	done_busy_a: assert property (o_burst_done_ff |-> !o_busy_ff &&
		$past(o_busy_ff)) else $error("done without busy fall");
	cover property (o_burst_done_ff);
	cover property (o_sym_valid_ff && !i_sym_ready);
	cover property (!o_word_ready && !o_busy_ff);
endmodule // bsf_formatter_props

bind bsf_formatter bsf_formatter_props bsf_formatter_props_inst (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_header_done(i_header_done),
	.o_word_ready(o_word_ready), .o_sym_ff(o_sym_ff),
	.o_sym_valid_ff(o_sym_valid_ff), .i_sym_ready(i_sym_ready),
	.o_busy_ff(o_busy_ff), .o_burst_done_ff(o_burst_done_ff));

/* File: testbench/bsf_formatter_tb_top.sv */
`timescale 1ns/1ps
module bsf_formatter_tb_top;
	reg i_sys_clk, i_reset, i_header_done, i_word_valid, i_word_tail, stall;
	reg [10:0] i_word;
	wire [3:0] o_sym_ff;
	wire o_word_ready, o_sym_valid_ff, sym_ready, o_busy_ff, done, take;
	int error_cnt, n_checks, cyc, dones;
	reg [31:0] rng;
	reg [5:0] st;
	reg [3:0] exp_sym;
	reg [3:0] exp_q[$];
	reg [11:0] wq[$];
	bsf_formatter bsf_formatter_inst (.i_sys_clk(i_sys_clk),
		.i_reset(i_reset), .i_header_done(i_header_done),
		.i_word_valid(i_word_valid), .i_word(i_word),
		.i_word_tail(i_word_tail), .o_word_ready(o_word_ready),
		.o_sym_ff(o_sym_ff), .o_sym_valid_ff(o_sym_valid_ff),
		.i_sym_ready(sym_ready), .o_busy_ff(o_busy_ff),
		.o_burst_done_ff(done));
	bsf_sym_sink bsf_sym_sink_inst (.i_sys_clk(i_sys_clk),
		.i_valid(o_sym_valid_ff), .i_stall(stall), .o_ready(sym_ready),
		.o_take(take));
	// Free-running 50 ns clock.
	initial
	begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// Xorshift source for words and stalls.
	function automatic [31:0] rnd();
	begin
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		rnd = rng;
	end
	endfunction
	// Reference encoder step; returns the code pair for one bit.
	function automatic [1:0] enc(input b);
		reg [6:0] t;
	begin
		t = {b, st};
		enc = {^(t & 7'h79), ^(t & 7'h5B)};
		st = {b, st[5:1]};
	end
	endfunction
	task automatic chk(input string nm, input logic [15:0] s, e);
	begin
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	end
	endtask
	task wrap_up;
	begin
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// Queues n words plus the tail pair and their expected symbols.
	task automatic plan(input int n);
		reg [10:0] w;
		reg [15:0] b;
	begin
		st = 6'h00;
		for (int i = 0; i < n; i++)
		begin
			w = (i == 0) ? 11'h7FF : 11'(rnd());
			wq.push_back({1'b0, w});
			exp_q.push_back({w[10:9], enc(w[8])});
			exp_q.push_back({w[7:6], enc(w[5])});
			exp_q.push_back({w[4:3], enc(w[2])});
			exp_q.push_back({w[1:0], 2'h0});
		end
		b = (n == 0) ? 16'hFFFF : 16'(rnd());
		wq.push_back({1'b1, b[15:5]});
		wq.push_back({1'b0, b[4:0], 6'h2A});
		for (int k = 0; k < 8; k++)
			exp_q.push_back({b[15 - 2 * k -: 2], k % 4 == 3 ? 2'h0 : enc(1'b0)});
	end
	endtask
	// One burst; the header comes late cycles after the words start.
	task automatic burst(input int n, input int late);
		int d0;
	begin
		d0 = dones;
		plan(n);
		fork
			begin
				while (wq.size() > 0)
				begin
					@(negedge i_sys_clk);
					{i_word_tail, i_word} = wq.pop_front();
					i_word_valid = 1'b1;
					while (!o_word_ready)
						@(negedge i_sys_clk);
					@(posedge i_sys_clk);
				end
				@(negedge i_sys_clk);
				i_word_valid = 1'b0;
			end
			begin
				repeat (late) @(negedge i_sys_clk);
				if (late > 0)
				begin
					chk("early symbol", o_sym_valid_ff, 1'b0);
					chk("ready when full", o_word_ready, 1'b0);
				end
				i_header_done = 1'b1;
				@(negedge i_sys_clk);
				i_header_done = 1'b0;
				repeat (6) @(negedge i_sys_clk);
				i_header_done = 1'b1;
				@(negedge i_sys_clk);
				i_header_done = 1'b0;
			end
		join
		while (exp_q.size() > 0)
			@(posedge i_sys_clk);
		repeat (4) @(negedge i_sys_clk);
		chk("done count", 16'(dones), 16'(d0 + 1));
		chk("busy", o_busy_ff, 1'b0);
		chk("stray symbol", o_sym_valid_ff, 1'b0);
	end
	endtask
	// Checks each taken symbol, counts done pulses, guards against hangs.
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (done === 1'b1)
			dones++;
		if (take === 1'b1)
		begin
			exp_sym = exp_q.size() ? exp_q.pop_front() : 4'hX;
			chk("symbol", o_sym_ff, exp_sym);
			chk("sym hi", o_sym_ff[3:2], exp_sym[3:2]);
			chk("sym lo", o_sym_ff[1:0], exp_sym[1:0]);
			chk("coded", o_sym_ff[1:0], exp_sym[1:0]);
		end
		if (cyc == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	// Random downstream stalls.
	always @(negedge i_sys_clk)
		stall <= (rnd() & 3) == 0;
	// Reset, then a late-header burst, an empty burst and random bursts.
	initial
	begin
		{i_reset, i_header_done, i_word_valid, i_word_tail} = 4'h8;
		{i_word, stall, st, rng} = {11'h000, 1'b0, 6'h00, 32'h96107F66};
		{error_cnt, n_checks, cyc, dones} = '0;
		repeat (3) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_reset = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		burst(9, 30);
		burst(0, 0);
		repeat (8) burst(int'(rnd() % 6), 0);
		wrap_up();
	end
endmodule // bsf_formatter_tb_top

/* File: testbench/bsf_sym_sink.sv */
`timescale 1ns/1ps
// Downstream symbol taker that stalls when asked.
module bsf_sym_sink (
	input wire i_sys_clk,
	input wire i_valid,
	input wire i_stall,
	output reg o_ready,
	output wire o_take
);
	// Ready moves on the falling edge, away from sampling.
	initial o_ready = 1'b0;
	always @(negedge i_sys_clk)
		o_ready <= !i_stall;
	// Marks a symbol handed over at the next rising edge.
	assign o_take = i_valid && o_ready;
endmodule // bsf_sym_sink
